// ==== design/dmalc_defines.vh ====
`ifndef DMALC_DEFINES_VH
`define DMALC_DEFINES_VH
`define DMALC_ADDR_STRAP 8'h37
`define DMALC_ADDR_DIV 8'h3A
`define DMALC_ADDR_EQ 8'h3B
`define DMALC_ADDR_ERR 8'h41
`define DMALC_ADDR_BCM 8'h43
`define DMALC_DIV_RST 8'h00
`define DMALC_ERR_RST 5'h03
`define DMALC_BCM_RST 5'h00
`define DMALC_DIV_OV_BIT 7
`define DMALC_DIV_INOV_BIT 2
`define DMALC_ERR_EN_BIT 4
`define DMALC_BCM_MISO_BIT 4
`define DMALC_BCM_CPOL_BIT 3
`define DMALC_MODE_NF_GPIO 3'h0
`define DMALC_MODE_HS_GPIO1 3'h1
`define DMALC_MODE_HS_GPIO2 3'h2
`define DMALC_MODE_HS_GPIO4 3'h3
`define DMALC_MODE_NF_FWD_SPI 3'h4
`define DMALC_MODE_NF_REV_SPI 3'h5
`define DMALC_MODE_HS_REV_SPI 3'h7
`endif

// ==== design/dmalc_regs.v ====
`timescale 1ns/1ps
`include "dmalc_defines.vh"
// register bank on the host control port; sys_clk is the pixel clock
module dmalc_regs (
  input wire sys_clk, // pixel clock
  input wire rst_n, // async reset, active low
  input wire reg_wr, // one-cycle write strobe
  input wire reg_rd, // one-cycle read strobe
  input wire [7:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // write data
  input wire strap_a_decode_done, // strap A decode finished (async)
  input wire [2:0] strap_a_decode_value, // strap A decoded value
  input wire strap_b_decode_done, // strap B decode finished (async)
  input wire [2:0] strap_b_decode_value, // strap B decoded value
  input wire [2:0] auto_out_divider, // pll_state_machine output divider choice
  input wire [1:0] auto_in_divider, // pll_state_machine input divider choice
  input wire [5:0] equalizer_level, // adaptive equalizer status (async)
  input wire err_link_clock_channel_a, // error pulse, clock channel a
  input wire err_link_clock_channel_b, // error pulse, clock channel b
  input wire err_control_data_channel, // error pulse, control data channel
  input wire link_lock_restart, // pulse: lock reacquired, clears counter
  input wire spi_slave_select_n, // slave select pin, active low
  input wire spi_miso_data, // slave output data from SPI engine
  output reg [7:0] reg_rdata, // read data, valid cycle after reg_rd
  output reg [5:0] out_divide_ratio, // effective output divide, 32..1
  output reg [3:0] in_divide_ratio, // effective input divide, 1..8
  output reg link_lock_loss, // pulse: drop link lock
  output reg spi_miso_o, // slave output pin value
  output reg spi_miso_oe, // slave output pin enable
  output reg spi_drive_rising, // drive data on rising serial clock
  output reg [2:0] back_channel_mode, // back-channel mode field
  output reg bc_spi_mode, // an SPI mode is selected
  output reg bc_reverse_spi, // a reverse-channel SPI mode is selected
  output reg bc_high_speed, // high-speed back-channel framing
  output reg [2:0] bc_gpio_count // high-speed GPIO count, 0 in normal frame
);
  reg [1:0] sa_done_sync_reg;
  reg [1:0] sb_done_sync_reg;
  reg [5:0] eq_s1_reg;
  reg [5:0] eq_s2_reg;
  reg [5:0] eq_s3_reg;
  reg [5:0] eq_hold_reg;
  reg [2:0] sa_val_s1_reg;
  reg [2:0] sa_val_s2_reg;
  reg [2:0] sb_val_s1_reg;
  reg [2:0] sb_val_s2_reg;
  reg [1:0] ss_sync_reg;
  reg [7:0] strap_reg;
  reg [7:0] div_reg;
  reg [4:0] err_reg;
  reg [4:0] bcm_reg;
  reg [3:0] err_cnt_reg;
  reg [3:0] err_cnt_next;
  reg [2:0] sel_div;
  reg [1:0] sel_in;
  reg lock_loss_next;
  reg [7:0] rd_next;
  wire err_any;
  wire err_en;
  wire ss_active;
  wire [2:0] mode_w;

  // done flags synchronised; values are stable once done is seen
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sa_done_sync_reg <= 2'h0;
      sb_done_sync_reg <= 2'h0;
      eq_s1_reg <= 6'h00;
      eq_s2_reg <= 6'h00;
      eq_s3_reg <= 6'h00;
      eq_hold_reg <= 6'h00;
      sa_val_s1_reg <= 3'h0;
      sa_val_s2_reg <= 3'h0;
      sb_val_s1_reg <= 3'h0;
      sb_val_s2_reg <= 3'h0;
      ss_sync_reg <= 2'h3;
    end
    else
    begin
      sa_done_sync_reg <= {sa_done_sync_reg[0], strap_a_decode_done};
      sb_done_sync_reg <= {sb_done_sync_reg[0], strap_b_decode_done};
      eq_s1_reg <= equalizer_level;
      eq_s2_reg <= eq_s1_reg;
      eq_s3_reg <= eq_s2_reg;
      // a multi-bit level may be caught mid-change; take it only when steady
      if (eq_s2_reg == eq_s3_reg)
        eq_hold_reg <= eq_s2_reg;
      sa_val_s1_reg <= strap_a_decode_value;
      sa_val_s2_reg <= sa_val_s1_reg;
      sb_val_s1_reg <= strap_b_decode_value;
      sb_val_s2_reg <= sb_val_s1_reg;
      ss_sync_reg <= {ss_sync_reg[0], spi_slave_select_n};
    end
  end

  // latched once; later writes cannot touch it
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      strap_reg <= 8'h00;
    else
    begin
      if (sb_done_sync_reg[1] && !strap_reg[7])
        strap_reg[7:4] <= {1'b1, sb_val_s2_reg};
      if (sa_done_sync_reg[1] && !strap_reg[3])
        strap_reg[3:0] <= {1'b1, sa_val_s2_reg};
    end
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= `DMALC_DIV_RST;
      err_reg <= `DMALC_ERR_RST;
      bcm_reg <= `DMALC_BCM_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `DMALC_ADDR_DIV: div_reg <= reg_wdata & 8'hF7;
        `DMALC_ADDR_ERR: err_reg <= reg_wdata[4:0];
        `DMALC_ADDR_BCM: bcm_reg <= reg_wdata[4:0];
        default: div_reg <= div_reg;
      endcase
    end
  end

  always @*
  begin
    case (reg_addr)
      `DMALC_ADDR_STRAP: rd_next = strap_reg;
      `DMALC_ADDR_DIV: rd_next = div_reg;
      `DMALC_ADDR_EQ: rd_next = {2'h0, eq_hold_reg};
      `DMALC_ADDR_ERR: rd_next = {3'h0, err_reg};
      `DMALC_ADDR_BCM: rd_next = {3'h0, bcm_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always @*
  begin
    sel_div = div_reg[`DMALC_DIV_OV_BIT] ? div_reg[6:4] : auto_out_divider;
    sel_in = div_reg[`DMALC_DIV_INOV_BIT] ? div_reg[1:0] : auto_in_divider;
  end

  // error inputs come from pixel-clock logic, so no synchroniser
  assign err_any = err_link_clock_channel_a | err_link_clock_channel_b |
                   err_control_data_channel;
  assign err_en = err_reg[`DMALC_ERR_EN_BIT];

  // channel errors in one cycle count as a single event
  always @*
  begin
    err_cnt_next = err_cnt_reg;
    lock_loss_next = 1'b0;
    if (link_lock_restart)
      err_cnt_next = 4'h0;
    else if (err_any)
    begin
      if (!err_en)
        lock_loss_next = 1'b1;
      else if (err_cnt_reg + 4'h1 >= err_reg[3:0])
      begin
        lock_loss_next = 1'b1;
        err_cnt_next = 4'h0;
      end
      else
        err_cnt_next = err_cnt_reg + 4'h1;
    end
  end

  assign ss_active = !ss_sync_reg[1];
  assign mode_w = bcm_reg[2:0];

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      out_divide_ratio <= 6'h20;
      in_divide_ratio <= 4'h1;
      link_lock_loss <= 1'b0;
      err_cnt_reg <= 4'h0;
      spi_miso_o <= 1'b0;
      spi_miso_oe <= 1'b0;
      spi_drive_rising <= 1'b0;
      back_channel_mode <= 3'h0;
      bc_spi_mode <= 1'b0;
      bc_reverse_spi <= 1'b0;
      bc_high_speed <= 1'b0;
      bc_gpio_count <= 3'h0;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= rd_next;
      case (sel_div)
        3'h0: out_divide_ratio <= 6'h20;
        3'h1: out_divide_ratio <= 6'h10;
        3'h2: out_divide_ratio <= 6'h08;
        3'h3: out_divide_ratio <= 6'h04;
        3'h4, 3'h5: out_divide_ratio <= 6'h02;
        default: out_divide_ratio <= 6'h01;
      endcase
      in_divide_ratio <= 4'h1 << sel_in;
      link_lock_loss <= lock_loss_next;
      err_cnt_reg <= err_cnt_next;
      spi_drive_rising <= bcm_reg[`DMALC_BCM_CPOL_BIT];
      back_channel_mode <= mode_w;
      bc_high_speed <= (mode_w == `DMALC_MODE_HS_GPIO1) || (mode_w == `DMALC_MODE_HS_GPIO2) ||
                       (mode_w == `DMALC_MODE_HS_GPIO4) || (mode_w == `DMALC_MODE_HS_REV_SPI);
      case (mode_w)
        `DMALC_MODE_HS_GPIO1: bc_gpio_count <= 3'h1;
        `DMALC_MODE_HS_GPIO2: bc_gpio_count <= 3'h2;
        `DMALC_MODE_HS_GPIO4: bc_gpio_count <= 3'h4;
        default: bc_gpio_count <= 3'h0;
      endcase
      bc_spi_mode <= mode_w[2] && (mode_w != 3'h6);
      bc_reverse_spi <= (mode_w == `DMALC_MODE_NF_REV_SPI) ||
                        (mode_w == `DMALC_MODE_HS_REV_SPI);
      spi_miso_o <= spi_miso_data;
      // bused slaves must release the line when not selected
      if ((mode_w == `DMALC_MODE_NF_REV_SPI) || (mode_w == `DMALC_MODE_HS_REV_SPI))
        spi_miso_oe <= !bcm_reg[`DMALC_BCM_MISO_BIT] || ss_active;
      else
        spi_miso_oe <= 1'b0;
    end
  end

endmodule

// ==== tb/dmalc_regs_chk.sv ====
`timescale 1ns/1ps
module dmalc_regs_chk (
  input logic sys_clk, // clock
  input logic rst_n, // async reset, active low
  input logic reg_wr, // write strobe
  input logic reg_rd, // read strobe
  input logic [7:0] reg_addr, // register address
  input logic [7:0] reg_wdata, // write data
  input logic [7:0] reg_rdata, // read data
  input logic err_link_clock_channel_a, // error pulse, clock channel a
  input logic err_link_clock_channel_b, // error pulse, clock channel b
  input logic err_control_data_channel, // error pulse, control data channel
  input logic [5:0] out_divide_ratio, // output divide
  input logic [3:0] in_divide_ratio, // input divide
  input logic link_lock_loss, // lock drop pulse
  input logic spi_miso_oe, // slave output enable
  input logic bc_spi_mode, // spi mode selected
  input logic bc_reverse_spi, // reverse spi selected
  input logic bc_high_speed, // high-speed framing
  input logic [2:0] back_channel_mode, // mode field
  input logic [2:0] bc_gpio_count // high-speed gpio count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic en_reg, any_err;
  assign any_err = err_link_clock_channel_a | err_link_clock_channel_b | err_control_data_channel;
  // shadow of the count enable, tracked from host writes
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) en_reg <= 1'b0;
    else if (reg_wr && reg_addr == 8'h41) en_reg <= reg_wdata[4];
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h50
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_div_bit3: assert property (reg_rd && reg_addr == 8'h3A |=> !reg_rdata[3])
    else $error("divider bit3 not zero");
  chk_eq_upper: assert property (reg_rd && reg_addr == 8'h3B
    |=> reg_rdata[7:6] == 2'h0) else $error("equalizer upper bits set");
  chk_out_ratio: assert property (out_divide_ratio inside
    {6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01}) else $error("bad output divide");
  chk_in_ratio: assert property (in_divide_ratio inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("bad input divide");
  chk_lock_single: assert property (!en_reg && any_err |=> link_lock_loss)
    else $error("no lock drop on error");
  chk_lock_cause: assert property (link_lock_loss |-> $past(any_err))
    else $error("lock drop without error");
  chk_gpio_count: assert property (bc_gpio_count == ((back_channel_mode == 3'h3) ? 3'h4
    : (back_channel_mode[2] ? 3'h0 : back_channel_mode))) else $error("gpio count wrong");
  chk_spi_decode: assert property (bc_spi_mode ==
    (back_channel_mode[2] && back_channel_mode != 3'h6)) else $error("spi mode decode wrong");
  chk_oe_idle: assert property (!bc_reverse_spi && !$past(bc_reverse_spi)
    |-> !spi_miso_oe) else $error("output enabled outside reverse spi");
  chk_hs_decode: assert property (bc_high_speed ==
    (back_channel_mode inside {3'h1, 3'h2, 3'h3, 3'h7})) else $error("high speed decode wrong");
  chk_rev_decode: assert property (bc_reverse_spi ==
    (back_channel_mode inside {3'h5, 3'h7})) else $error("reverse spi decode wrong");
endmodule
bind dmalc_regs dmalc_regs_chk u_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .err_link_clock_channel_a(err_link_clock_channel_a),
  .err_link_clock_channel_b(err_link_clock_channel_b),
  .err_control_data_channel(err_control_data_channel),
  .out_divide_ratio(out_divide_ratio),
  .in_divide_ratio(in_divide_ratio),
  .link_lock_loss(link_lock_loss),
  .spi_miso_oe(spi_miso_oe),
  .bc_spi_mode(bc_spi_mode),
  .bc_reverse_spi(bc_reverse_spi),
  .bc_high_speed(bc_high_speed),
  .back_channel_mode(back_channel_mode),
  .bc_gpio_count(bc_gpio_count)
);

// ==== tb/dmalc_regs_tb_top.sv ====
`timescale 1ns/1ps
module dmalc_regs_tb_top;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, ad = 0, bd = 0, ea = 0, eb = 0, ec = 0, ss_n = 1;
  logic rs = 0, md = 0, mo;
  logic [7:0] addr = '0, wd = '0, rdat;
  logic [2:0] av = 3'h5, bv = 3'h2, bcm, gpn;
  logic [5:0] eq = '0, odv;
  logic [3:0] idv;
  logic loss, oe, rise, spm, rev, hs;
  logic [5:0] otab [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h01};
  int miscompares = 0, checked = 0;
  dmalc_regs DUT (.sys_clk(clk), .rst_n(rst_n), .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr),
    .reg_wdata(wd), .strap_a_decode_done(ad), .strap_a_decode_value(av),
    .strap_b_decode_done(bd), .strap_b_decode_value(bv), .auto_out_divider(3'h2),
    .auto_in_divider(2'h1), .equalizer_level(eq), .err_link_clock_channel_a(ea),
    .err_link_clock_channel_b(eb), .err_control_data_channel(ec), .link_lock_restart(rs),
    .spi_slave_select_n(ss_n), .spi_miso_data(md), .reg_rdata(rdat), .out_divide_ratio(odv),
    .in_divide_ratio(idv), .link_lock_loss(loss), .spi_miso_o(mo), .spi_miso_oe(oe),
    .spi_drive_rising(rise), .back_channel_mode(bcm), .bc_spi_mode(spm), .bc_reverse_spi(rev),
    .bc_high_speed(hs), .bc_gpio_count(gpn));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) {wr_s, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr_s <= 1'b0;
    // derived outputs follow the register a cycle later
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk) {rd_s, addr} <= {1'b1, a};
    @(posedge clk) rd_s <= 1'b0;
    @(posedge clk) #1 chk(rdat, exp);
  endtask
  task automatic pulse(input int ch, input logic exp);
    @(posedge clk) {ea, eb, ec} <= 3'h4 >> ch;
    @(posedge clk) {ea, eb, ec} <= 3'h0;
    #1 chk(loss, exp);
  endtask
  task automatic t_reset;
    rd(8'h37, 8'h00); rd(8'h3A, 8'h00); rd(8'h3B, 8'h00);
    rd(8'h41, 8'h03); rd(8'h43, 8'h00); rd(8'h50, 8'h00);
    chk(odv, 8'h08); chk(idv, 8'h02);
  endtask
  task automatic t_strap;
    @(posedge clk) {ad, bd} <= 2'h3;
    repeat (5) @(posedge clk);
    {av, bv} <= 6'h00;
    wr(8'h37, 8'hFF);
    rd(8'h37, 8'hAD);
  endtask
  task automatic t_eq;
    @(posedge clk) eq <= 6'h2A;
    wr(8'h3B, 8'hFF);
    rd(8'h3B, 8'h2A);
  endtask
  task automatic t_div;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h3A, {1'b1, c[2:0], 2'h1, c[1:0]});
      chk(odv, otab[c]);
      chk(idv, 4'h1 << c[1:0]);
    end
    wr(8'h3A, 8'hFF); rd(8'h3A, 8'hF7);
    wr(8'h3A, 8'h00); chk(odv, 8'h08);
    chk(idv, 8'h02);
  endtask
  task automatic t_err;
    wr(8'h41, 8'hE0); rd(8'h41, 8'h00);
    pulse(0, 1'b1);
    wr(8'h41, 8'h13);
    pulse(1, 1'b0); pulse(2, 1'b0); pulse(0, 1'b1);
    wr(8'h41, 8'h03); pulse(1, 1'b1);
    // an error counted while disabled would make this first pulse drop lock
    wr(8'h41, 8'h12); pulse(2, 1'b0);
    @(posedge clk) rs <= 1'b1;
    @(posedge clk) rs <= 1'b0;
    pulse(2, 1'b0); pulse(0, 1'b1);
  endtask
  task automatic t_bcm;
    for (int m = 0; m < 8; m++)
    begin
      // code 110 is reserved and stays unused
      if (m == 6) continue;
      wr(8'h43, {5'h01, m[2:0]});
      chk(gpn, (m == 3) ? 3'h4 : (m < 3 ? m[2:0] : 3'h0));
      chk({spm, rev, hs, bcm}, {m > 3, m == 5 || m == 7, m inside {1, 2, 3, 7}, m[2:0]});
      chk(rise, 1'b1);
    end
    wr(8'h43, 8'h00); chk({rise, oe}, 8'h00);
    wr(8'h43, 8'h05); chk(oe, 1'b1);
    wr(8'h43, 8'h15); chk(oe, 1'b0);
    @(posedge clk) ss_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk(oe, 1'b1);
    @(posedge clk) md <= 1'b1;
    @(posedge clk) #1 chk(mo, 1'b1);
  endtask
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset; t_strap; t_eq; t_div; t_err; t_bcm;
    results;
  end
  initial
  begin
    #200000;
    miscompares++;
    results;
  end
endmodule
